// file: core/sdc_regs.sv
// APB register bank for divider, delay and fractional engine settings.
// Assumes APB3 with zero wait states; settings are registered outputs.
`timescale 1ns/1ps
`default_nettype none
module sdc_regs
  import sdc_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Settings to calibration, dividers and fractional engine
  output sdc_cfg_t cfg
);

  typedef struct packed {
    sdc_regs_t regs;
    logic [31:0] rdata;
    logic slverr;
    logic ready;
    logic load;
    sdc_cfg_t cfg;
  } sdc_state_t;

  sdc_state_t st_ff;
  sdc_state_t nxt_st;
  sdc_cfg_t cfg_next;

  // True when paddr is word aligned inside the index space
  function automatic logic sdc_aligned(input logic [31:0] a);
    sdc_aligned = (a[1:0] == 2'h0) && (a[31:8] == 24'h000000);
  endfunction : sdc_aligned

  function automatic logic [15:0] sdc_merge(input logic [15:0] old, input logic [15:0] wd,
                                            input logic [15:0] mask);
    sdc_merge = (old & ~mask) | (wd & mask);
  endfunction : sdc_merge

  localparam sdc_regs_t REGS_RST = '{
    core: SDC_RST_CORE, seg: SDC_RST_SEG, nup: SDC_RST_NUP, nlo: SDC_RST_NLO,
    dly: SDC_RST_DLY, denu: SDC_RST_DENU, denl: SDC_RST_DENL, seedu: SDC_RST_ZERO,
    seedl: SDC_RST_ZERO, numu: SDC_RST_ZERO, numl: SDC_RST_ZERO};

  // Settings seen while in reset, derived from the register reset values
  localparam sdc_cfg_t CFG_RST = '{
    osc_core_select: SDC_RST_CORE[SDC_CORE_SEL_LSB +: 3],
    osc_core_force: SDC_RST_CORE[SDC_CORE_FORCE_BIT],
    first_halving_enable: SDC_RST_SEG[SDC_SEG1_BIT],
    feedback_div: {SDC_RST_NUP[2:0], SDC_RST_NLO},
    detector_delay_setting: SDC_RST_DLY[SDC_DLY_LSB +: 6],
    detector_delay_cycles: 9'((9'(SDC_RST_DLY[SDC_DLY_LSB +: 6]) + SDC_DLY_OFFSET)
                              << SDC_DLY_SCALE_SHIFT),
    frac_denominator: {SDC_RST_DENU, SDC_RST_DENL},
    frac_numerator: {SDC_RST_ZERO, SDC_RST_ZERO},
    engine_seed: {SDC_RST_ZERO, SDC_RST_ZERO},
    seed_load: 1'b0};

  logic setup;
  logic [5:0] idx;
  logic [15:0] wd;
  logic hit;
  logic [15:0] rd;

  assign setup = psel && !penable;
  assign idx = paddr[7:2];
  assign wd = pwdata[15:0];

  sdc_cfg_map i_sdc_cfg_map (
    .regs(nxt_st.regs),
    .seed_load(nxt_st.load),
    .cfg(cfg_next)
  );

  always_comb begin
    nxt_st = st_ff;
    nxt_st.ready = 1'b0;
    nxt_st.load = 1'b0;
    hit = 1'b1;
    rd = 16'h0000;
    // Decode at setup so the answer is ready in the access cycle
    unique case (idx)
      SDC_IDX_CORE: rd = st_ff.regs.core & SDC_MASK_CORE;
      SDC_IDX_SEG: rd = st_ff.regs.seg & SDC_MASK_SEG;
      SDC_IDX_NUP: rd = st_ff.regs.nup & SDC_MASK_NUP;
      SDC_IDX_NLO: rd = st_ff.regs.nlo;
      SDC_IDX_DLY: rd = st_ff.regs.dly & SDC_MASK_DLY;
      SDC_IDX_DENU: rd = st_ff.regs.denu;
      SDC_IDX_DENL: rd = st_ff.regs.denl;
      SDC_IDX_SEEDU: rd = st_ff.regs.seedu;
      SDC_IDX_SEEDL: rd = st_ff.regs.seedl;
      SDC_IDX_NUMU: rd = st_ff.regs.numu;
      SDC_IDX_NUML: rd = st_ff.regs.numl;
      SDC_IDX_LOAD: rd = 16'h0000;
      default: hit = 1'b0;
    endcase
    if (!sdc_aligned(paddr)) begin
      hit = 1'b0;
    end
    if (setup) begin
      nxt_st.ready = 1'b1;
      nxt_st.slverr = !hit;
      nxt_st.rdata = (!pwrite && hit) ? {16'h0000, rd} : 32'h00000000;
      if (pwrite && hit) begin
        unique case (idx)
          SDC_IDX_CORE: begin
            nxt_st.regs.core = sdc_merge(st_ff.regs.core, wd, SDC_MASK_CORE);
          end
          SDC_IDX_SEG: nxt_st.regs.seg = sdc_merge(st_ff.regs.seg, wd, SDC_MASK_SEG);
          SDC_IDX_NUP: nxt_st.regs.nup = sdc_merge(st_ff.regs.nup, wd, SDC_MASK_NUP);
          SDC_IDX_NLO: nxt_st.regs.nlo = wd;
          SDC_IDX_DLY: nxt_st.regs.dly = sdc_merge(st_ff.regs.dly, wd, SDC_MASK_DLY);
          SDC_IDX_DENU: nxt_st.regs.denu = wd;
          SDC_IDX_DENL: nxt_st.regs.denl = wd;
          SDC_IDX_SEEDU: nxt_st.regs.seedu = wd;
          SDC_IDX_SEEDL: nxt_st.regs.seedl = wd;
          SDC_IDX_NUMU: nxt_st.regs.numu = wd;
          SDC_IDX_NUML: nxt_st.regs.numl = wd;
          SDC_IDX_LOAD: nxt_st.load = wd[SDC_LOAD_BIT];
          default: nxt_st.slverr = 1'b1;
        endcase
      end
    end
    nxt_st.cfg = cfg_next;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff.regs <= REGS_RST;
      st_ff.rdata <= 32'h00000000;
      st_ff.slverr <= 1'b0;
      st_ff.ready <= 1'b0;
      st_ff.load <= 1'b0;
      st_ff.cfg <= CFG_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Ready is a registered pulse in the access cycle: one wait-free answer
  assign pready = st_ff.ready;
  assign prdata = st_ff.rdata;
  assign pslverr = st_ff.slverr;
  assign cfg = st_ff.cfg;

endmodule : sdc_regs
`default_nettype wire

// file: core/sdc_pkg.sv
// Constants and carrier types for the synthesizer divider configuration bank.
// Assumes a 32-bit APB master on pclk; registers are 16 bits, one per word.
// How it works
// - Core select field seeds calibration start core
// - Force bit holds oscillator on selected core
// - Segment-one bit enables first divide-by-2
// - Feedback divider 19 bits: 3 upper, 16 lower
// - Lower divider half at 0x24, resets 0x46
// - Detector delay is (setting+3)*4 oscillator cycles
// - Denominator halves at 0x26/0x27, reset FD51/DA80
// - Numerator upper half at 0x2A, resets zero
// - Seed loads as fractional engine initial state
// - Seed halves at 0x28/0x29, reset zero
// - Numerator lower half at 0x2B, resets zero
package sdc_pkg;

  // Register indices; byte address is four times the index
  localparam logic [5:0] SDC_IDX_CORE = 6'h14;
  localparam logic [5:0] SDC_IDX_SEG = 6'h1F;
  localparam logic [5:0] SDC_IDX_NUP = 6'h22;
  localparam logic [5:0] SDC_IDX_NLO = 6'h24;
  localparam logic [5:0] SDC_IDX_DLY = 6'h25;
  localparam logic [5:0] SDC_IDX_DENU = 6'h26;
  localparam logic [5:0] SDC_IDX_DENL = 6'h27;
  localparam logic [5:0] SDC_IDX_SEEDU = 6'h28;
  localparam logic [5:0] SDC_IDX_SEEDL = 6'h29;
  localparam logic [5:0] SDC_IDX_NUMU = 6'h2A;
  localparam logic [5:0] SDC_IDX_NUML = 6'h2B;
  // Own: seed load strobe, bit 0 writes a one-shot load
  localparam logic [5:0] SDC_IDX_LOAD = 6'h30;

  // Field positions
  localparam int SDC_CORE_SEL_LSB = 11;
  localparam int SDC_CORE_FORCE_BIT = 10;
  localparam int SDC_SEG1_BIT = 14;
  localparam int SDC_DLY_LSB = 8;
  localparam int SDC_LOAD_BIT = 0;

  // Write masks for mixed registers; reserved bits read zero
  localparam logic [15:0] SDC_MASK_CORE = 16'h3C00;
  localparam logic [15:0] SDC_MASK_SEG = 16'h4000;
  localparam logic [15:0] SDC_MASK_NUP = 16'h0007;
  localparam logic [15:0] SDC_MASK_DLY = 16'h3F00;
  localparam logic [15:0] SDC_MASK_FULL = 16'hFFFF;

  // Reset values; undefined resets are taken as zero
  localparam logic [15:0] SDC_RST_CORE = 16'h0000;
  localparam logic [15:0] SDC_RST_SEG = 16'h0000;
  localparam logic [15:0] SDC_RST_NUP = 16'h0000;
  localparam logic [15:0] SDC_RST_NLO = 16'h0046;
  localparam logic [15:0] SDC_RST_DLY = 16'h0400;
  localparam logic [15:0] SDC_RST_DENU = 16'hFD51;
  localparam logic [15:0] SDC_RST_DENL = 16'hDA80;
  localparam logic [15:0] SDC_RST_ZERO = 16'h0000;

  // Delay arithmetic constants
  localparam logic [8:0] SDC_DLY_OFFSET = 9'h003;
  localparam int SDC_DLY_SCALE_SHIFT = 2;

  // Settings delivered to the analog and datapath blocks
  typedef struct packed {
    logic [2:0] osc_core_select;
    logic osc_core_force;
    logic first_halving_enable;
    logic [18:0] feedback_div;
    logic [5:0] detector_delay_setting;
    logic [8:0] detector_delay_cycles;
    logic [31:0] frac_denominator;
    logic [31:0] frac_numerator;
    logic [31:0] engine_seed;
    logic seed_load;
  } sdc_cfg_t;

  // Register storage
  typedef struct packed {
    logic [15:0] core;
    logic [15:0] seg;
    logic [15:0] nup;
    logic [15:0] nlo;
    logic [15:0] dly;
    logic [15:0] denu;
    logic [15:0] denl;
    logic [15:0] seedu;
    logic [15:0] seedl;
    logic [15:0] numu;
    logic [15:0] numl;
  } sdc_regs_t;

endpackage : sdc_pkg

// file: core/sdc_cfg_map.sv
// Combines stored halves into the settings bundle seen by the datapath.
// Assumes a register snapshot on the same clock; purely combinational.
`timescale 1ns/1ps
`default_nettype none
module sdc_cfg_map
  import sdc_pkg::*;
(
  // Register snapshot
  input wire sdc_regs_t regs,
  input wire logic seed_load,
  // Settings out
  output sdc_cfg_t cfg
);

  function automatic logic [31:0] sdc_join(input logic [15:0] hi, input logic [15:0] lo);
    sdc_join = {hi, lo};
  endfunction : sdc_join

  always_comb begin
    cfg.osc_core_select = regs.core[SDC_CORE_SEL_LSB +: 3];
    cfg.osc_core_force = regs.core[SDC_CORE_FORCE_BIT];
    cfg.first_halving_enable = regs.seg[SDC_SEG1_BIT];
    cfg.feedback_div = {regs.nup[2:0], regs.nlo};
    cfg.detector_delay_setting = regs.dly[SDC_DLY_LSB +: 6];
    // Delay in oscillator cycles, 12 .. 264
    cfg.detector_delay_cycles = 9'((9'(regs.dly[SDC_DLY_LSB +: 6]) + SDC_DLY_OFFSET)
                                   << SDC_DLY_SCALE_SHIFT);
    cfg.frac_denominator = sdc_join(regs.denu, regs.denl);
    cfg.frac_numerator = sdc_join(regs.numu, regs.numl);
    cfg.engine_seed = sdc_join(regs.seedu, regs.seedl);
    cfg.seed_load = seed_load;
  end

endmodule : sdc_cfg_map
`default_nettype wire

// file: test/sdc_assertions.sv
// Bus and settings checks for the divider configuration bank.
// Assumes one APB master on pclk and the zero-wait contract of sdc_regs.
`timescale 1ns/1ps
`default_nettype none
module sdc_assertions
  import sdc_pkg::*;
(
  // Clock, reset and bus
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  // Responses
  input wire logic pready,
  input wire logic pslverr,
  input wire sdc_cfg_t cfg
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic wr;
  logic [15:0] wd;
  assign wr = psel & ~penable & pwrite;
  assign wd = pwdata[15:0];
  chk_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  chk_unmapped_err: assert property (psel && !penable && paddr == 32'h60 |=> pslverr)
    else $error("unmapped access not refused");
  chk_core_fields: assert property (wr && paddr == 32'h50 |=>
    cfg.osc_core_select == $past(wd[13:11]) && cfg.osc_core_force == $past(wd[10]))
    else $error("core fields not taken");
  chk_halving_bit: assert property (wr && paddr == 32'h7C |=>
    cfg.first_halving_enable == $past(wd[14])) else $error("halving bit not taken");
  chk_div_upper: assert property (wr && paddr == 32'h88 |=>
    cfg.feedback_div[18:16] == $past(wd[2:0])) else $error("divider upper bits wrong");
  chk_div_lower: assert property (wr && paddr == 32'h90 |=>
    cfg.feedback_div[15:0] == $past(wd)) else $error("divider lower bits wrong");
  chk_delay_formula: assert property (
    cfg.detector_delay_cycles == ({3'h0, cfg.detector_delay_setting} + 9'h003) * 9'h004)
    else $error("delay cycles wrong");
  chk_den_upper: assert property (wr && paddr == 32'h98 |=>
    cfg.frac_denominator[31:16] == $past(wd)) else $error("denominator upper wrong");
  chk_den_lower: assert property (wr && paddr == 32'h9C |=>
    cfg.frac_denominator[15:0] == $past(wd)) else $error("denominator lower wrong");
  chk_seed_lower: assert property (wr && paddr == 32'hA4 |=>
    cfg.engine_seed[15:0] == $past(wd)) else $error("seed lower wrong");
  chk_num_upper: assert property (wr && paddr == 32'hA8 |=>
    cfg.frac_numerator[31:16] == $past(wd)) else $error("numerator upper wrong");
  chk_seed_strobe: assert property (wr && paddr == 32'hC0 && wd[0] |=> cfg.seed_load)
    else $error("seed load not pulsed");
  chk_seed_pulse: assert property (cfg.seed_load |=> !cfg.seed_load)
    else $error("seed load longer than one cycle");
endmodule : sdc_assertions
`default_nettype wire

// file: test/sdc_regs_tb.sv
// Self-checking bench for sdc_regs over APB.
// Assumes the bank answers each access phase with a one-cycle pready.
`timescale 1ns/1ps
`default_nettype none
module sdc_regs_tb
  import sdc_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  sdc_cfg_t cfg;
  logic [31:0] rd;
  logic err;
  logic ld;
  int mismatches = 0;
  int cmp_count = 0;
  logic [31:0] adr [11] = '{32'h50, 32'h7C, 32'h88, 32'h90, 32'h94, 32'h98, 32'h9C,
    32'hA0, 32'hA4, 32'hA8, 32'hAC};
  logic [15:0] rst [11] = '{16'h0, 16'h0, 16'h0, 16'h46, 16'h400, 16'hFD51, 16'hDA80,
    16'h0, 16'h0, 16'h0, 16'h0};
  logic [15:0] msk [11] = '{16'h3C00, 16'h4000, 16'h7, 16'hFFFF, 16'h3F00, 16'hFFFF,
    16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF};

  sdc_regs i_sdc_regs (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cfg(cfg));

  initial forever #4 pclk = ~pclk;

  task automatic test_done();
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One idle edge before setup keeps every signal to one assignment per step
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      mismatches++;
      test_done();
    end
    rd = prdata;
    err = pslverr;
    ld = cfg.seed_load;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rdc

  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    chk(32'(cfg.feedback_div), 32'h46);
    chk(32'(cfg.detector_delay_cycles), 32'd28);
    chk(32'(cfg.detector_delay_setting), 32'h4);
    chk(cfg.frac_denominator, 32'hFD51DA80);
    for (int i = 0; i < 11; i++) rdc(adr[i], {16'h0, rst[i]});
    for (int i = 0; i < 11; i++) xfer(1'b1, adr[i], 32'hFFFFFFFF);
    for (int i = 0; i < 11; i++) rdc(adr[i], {16'h0, msk[i]});
    chk(32'(cfg.detector_delay_cycles), 32'h108);
    chk(32'({cfg.osc_core_select, cfg.osc_core_force, cfg.first_halving_enable}),
      32'h1F);
    chk(cfg.frac_numerator, 32'hFFFFFFFF);
    xfer(1'b1, 32'h88, 32'h5);
    xfer(1'b1, 32'h90, 32'h1234);
    chk(32'(cfg.feedback_div), 32'h51234);
    xfer(1'b1, 32'hA0, 32'hA5A5);
    xfer(1'b1, 32'hA4, 32'h5A5A);
    chk(cfg.engine_seed, 32'hA5A55A5A);
    xfer(1'b1, 32'hC0, 32'h1);
    chk(32'(ld), 32'h1);
    xfer(1'b1, 32'hC0, 32'h0);
    chk(32'(ld), 32'h0);
    xfer(1'b1, 32'h50, 32'h2800);
    xfer(1'b1, 32'h7C, 32'h0);
    xfer(1'b1, 32'h94, 32'h0);
    chk(32'({cfg.osc_core_select, cfg.osc_core_force, cfg.first_halving_enable}),
      32'h14);
    chk(32'(cfg.detector_delay_cycles), 32'd12);
    chk(32'(cfg.detector_delay_setting), 32'h0);
    xfer(1'b1, 32'h51, 32'hFFFF);
    chk(32'(err), 32'h1);
    rdc(32'h50, 32'h2800);
    rdc(32'h60, 32'h0);
    chk(32'(err), 32'h1);
    // Second reset in mid-run must bring every setting back
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    chk(32'(cfg.detector_delay_cycles), 32'd28);
    chk(cfg.engine_seed, 32'h0);
    rdc(32'h90, 32'h46);
    test_done();
  end
endmodule : sdc_regs_tb

bind sdc_regs sdc_assertions i_sdc_assertions (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .cfg(cfg));
`default_nettype wire
